// ==== hw/fsg_guard.sv ====
// Flash self-programming section guard with APB register access
`timescale 1ns/1ps
module fsg_guard
  import fsg_pkg::*;
#(
  parameter logic [ADDR_W-1:0] STALL_START = STALL_START_D,
  parameter logic [ADDR_W-1:0] LDR_START   = LDR_START_D,
  parameter int                PROG_CYCLES = PROG_CYCLES_D
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  input  wire logic              op_req,
  input  wire logic [1:0]        op_kind,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [3:0]        op_data,
  input  wire logic              lpm_req,
  input  wire logic [ADDR_W-1:0] lpm_addr,
  input  wire logic              vec_in_loader,
  input  wire logic              chip_erase,
  input  wire logic              ext_lock_wr,
  input  wire logic [3:0]        ext_lock_data,
  output logic                   cpu_halt,
  output logic                   region_blocked,
  output logic                   op_active,
  output logic                   op_accept,
  output logic                   op_reject,
  output logic                   lpm_grant,
  output logic                   lpm_deny,
  output logic                   irq_mask
);

  // Loader start forced into the stall region
  localparam logic [ADDR_W-1:0] LDR_EFF =
    (LDR_START < STALL_START) ? STALL_START : LDR_START;
  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

  // Complete state of the guard
  typedef struct packed {
    fsg_state_type     state;     // Sequencer state
    logic              tgt_stall; // Latched target class
    logic [CNT_W-1:0]  cnt;       // Remaining programming cycles
    logic              busy;      // Region busy flag
    logic [3:0]        lock;      // Both lock pairs
    logic              halt;      // CPU halt
    logic              active;    // Operation in progress
    logic              accept;    // Operation accepted pulse
    logic              reject;    // Operation refused pulse
    logic              lgrant;    // Load granted pulse
    logic              ldeny;     // Load denied pulse
    logic              imask;     // Interrupt mask
    logic              pready;    // APB ready
    logic              pslverr;   // APB error
    logic [31:0]       prdata;    // APB read data
  } fsg_regs_type;

  fsg_regs_type st;       // Registered state
  fsg_regs_type next_st;  // Next state

  // Decoded helper terms
  logic fetch_in_ldr;   // CPU executes loader code
  logic op_tgt_ldr;     // Store targets loader section
  logic lpm_tgt_ldr;    // Load targets loader section
  logic store_locked;   // Store blocked by lock pair
  logic apb_setup;      // APB setup phase
  logic apb_write;      // APB write taking effect
  logic reen_wr;        // Re-enable bit written

  // Section decode from addresses
  always_comb begin
    fetch_in_ldr = (fetch_addr >= LDR_EFF);
    op_tgt_ldr   = (op_addr >= LDR_EFF);
    lpm_tgt_ldr  = (lpm_addr >= LDR_EFF);
    // Only boot lock pairs gate stores; general locks ignored
    if (op_tgt_ldr) begin
      store_locked = !st.lock[LK_LDR_LOW];
    end else begin
      store_locked = !st.lock[LK_APP_LOW];
    end
    apb_setup = psel && !penable;
    apb_write = psel && penable && st.pready && pwrite
                && !st.pslverr;
    reen_wr   = apb_write && (paddr == OFS_CTRL)
                && pwdata[CS_REENABLE];
  end

  // Next-state logic
  always_comb begin
    next_st        = st;
    next_st.accept = 1'b0;
    next_st.reject = 1'b0;
    next_st.lgrant = 1'b0;
    next_st.ldeny  = 1'b0;

    // APB answer prepared in setup, given in access
    next_st.pready  = apb_setup;
    next_st.pslverr = 1'b0;
    next_st.prdata  = '0;
    if (apb_setup) begin
      if (paddr == OFS_CTRL) begin
        next_st.prdata[CS_BUSY]   = st.busy;
        next_st.prdata[CS_ACTIVE] = (st.state == ST_PROG);
        next_st.prdata[CS_STALL]  = st.tgt_stall;
      end else if (paddr == OFS_LOCK) begin
        next_st.prdata[3:0] = st.lock;
      end else begin
        next_st.pslverr = 1'b1; // Unmapped address
      end
    end

    // Re-enable write clears busy once operation is over
    if (reen_wr && st.state == ST_IDLE) begin
      next_st.busy = 1'b0;
    end

    // Chip erase returns locks to unprogrammed
    if (chip_erase) begin
      next_st.lock = LOCK_RESET;
    end
    // Software and external programming only clear lock bits
    if (apb_write && paddr == OFS_LOCK) begin
      next_st.lock = next_st.lock & pwdata[3:0];
    end
    if (ext_lock_wr) begin
      next_st.lock = next_st.lock & ext_lock_data;
    end

    // Sequencer
    unique case (st.state)
      ST_IDLE: begin
        if (op_req) begin
          // Only loader code may start a store
          if (!fetch_in_ldr) begin
            next_st.reject = 1'b1;
          end else if (op_kind == OPK_LOCK) begin
            next_st.lock   = next_st.lock & op_data;
            next_st.accept = 1'b1;
          end else if (op_kind != OPK_ERASE
                       && op_kind != OPK_WRITE) begin
            next_st.reject = 1'b1; // Illegal kind
          end else if (store_locked) begin
            next_st.reject = 1'b1;
          end else begin
            // Class from the programmed address
            next_st.accept    = 1'b1;
            next_st.state     = ST_PROG;
            next_st.tgt_stall = (op_addr >= STALL_START);
            next_st.cnt       = PROG_LAST;
            if (op_addr < STALL_START) begin
              next_st.busy = 1'b1; // Set wins
            end
          end
        end
      end
      ST_PROG: begin
        // Requests during an operation are refused
        if (op_req) begin
          next_st.reject = 1'b1;
        end
        if (st.cnt == CNT_ZERO) begin
          next_st.state = ST_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
    endcase

    // Halt only for stall-region targets
    next_st.halt = (next_st.state == ST_PROG) && next_st.tgt_stall;
    next_st.active = (next_st.state == ST_PROG);

    // Program-load check across sections
    if (lpm_req) begin
      if (fetch_in_ldr && !lpm_tgt_ldr
          && !st.lock[LK_APP_HIGH]) begin
        next_st.ldeny = 1'b1;
      end else if (!fetch_in_ldr && lpm_tgt_ldr
                   && !st.lock[LK_LDR_HIGH]) begin
        next_st.ldeny = 1'b1;
      end else if (st.busy && lpm_addr < STALL_START) begin
        next_st.ldeny = 1'b1; // Region unreadable
      end else begin
        next_st.lgrant = 1'b1;
      end
    end

    // Interrupt masking across sections
    next_st.imask =
      (!fetch_in_ldr && vec_in_loader && !st.lock[LK_APP_HIGH]) ||
      (fetch_in_ldr && !vec_in_loader && !st.lock[LK_LDR_HIGH]);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.state     <= ST_IDLE;
      st.lock      <= LOCK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign cpu_halt       = st.halt;
  assign region_blocked = st.busy;
  assign op_active      = st.active;
  assign op_accept      = st.accept;
  assign op_reject      = st.reject;
  assign lpm_grant      = st.lgrant;
  assign lpm_deny       = st.ldeny;
  assign irq_mask       = st.imask;

  // Halt only while a stall-region operation runs
  a_halt_stall: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_halt |-> op_active && st.tgt_stall)
    else $error("halt without stall-region operation");

  // Concurrent-region operation never halts
  a_no_halt_rww: assert property (@(posedge pclk) disable iff (!presetn)
    op_active && !st.tgt_stall |-> !cpu_halt)
    else $error("halt during concurrent-region operation");

  // Busy shown throughout concurrent-region operation
  a_busy_rww: assert property (@(posedge pclk) disable iff (!presetn)
    op_active && !st.tgt_stall |-> region_blocked)
    else $error("busy flag low while region blocked");

  // Busy sticky until re-enable write
  a_busy_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    region_blocked && !reen_wr |=> region_blocked)
    else $error("busy flag dropped without re-enable");

  // Re-enable clears busy when idle
  a_reen_clear: assert property (@(posedge pclk) disable iff (!presetn)
    reen_wr && !op_active && !op_req |=> !region_blocked)
    else $error("re-enable did not clear busy flag");

  // Accepted store came from loader code
  a_store_ldr: assert property (@(posedge pclk) disable iff (!presetn)
    op_accept |-> $past(fetch_in_ldr))
    else $error("store accepted outside loader code");

  // Lock bits return to one only by chip erase
  a_lock_erase: assert property (@(posedge pclk) disable iff (!presetn)
    (st.lock & ~$past(st.lock)) != 4'h0 |-> $past(chip_erase))
    else $error("lock bit erased without chip erase");

  // Application store refused under low lock bit
  a_app_store: assert property (@(posedge pclk) disable iff (!presetn)
    op_req && !op_active && fetch_in_ldr && !op_tgt_ldr
    && op_kind == OPK_WRITE && !st.lock[LK_APP_LOW]
    |=> op_reject && !op_active)
    else $error("store to locked application section");

  // Loader loads of application denied under high lock bit
  a_app_load: assert property (@(posedge pclk) disable iff (!presetn)
    lpm_req && fetch_in_ldr && !lpm_tgt_ldr
    && !st.lock[LK_APP_HIGH] |=> lpm_deny)
    else $error("loader load of locked application");

  // Target class held for the whole operation
  a_class_held: assert property (@(posedge pclk) disable iff (!presetn)
    op_active && $past(op_active) |-> $stable(st.tgt_stall))
    else $error("target class changed mid-operation");

  // Stall-region operation halts for its whole length
  a_halt_whole: assert property (@(posedge pclk) disable iff (!presetn)
    op_active && st.tgt_stall |-> cpu_halt)
    else $error("no halt during stall-region operation");

  // Loader store refused under low loader lock bit
  a_ldr_store: assert property (@(posedge pclk) disable iff (!presetn)
    op_req && !op_active && fetch_in_ldr && op_tgt_ldr
    && (op_kind == OPK_ERASE || op_kind == OPK_WRITE)
    && !st.lock[LK_LDR_LOW] |=> op_reject && !op_active)
    else $error("store to locked loader section");

  // Application loads of loader denied under high lock bit
  a_ldr_load: assert property (@(posedge pclk) disable iff (!presetn)
    lpm_req && !fetch_in_ldr && lpm_tgt_ldr
    && !st.lock[LK_LDR_HIGH] |=> lpm_deny)
    else $error("application load of locked loader");

  // Interrupts masked in application code under high lock bit
  a_app_mask: assert property (@(posedge pclk) disable iff (!presetn)
    !fetch_in_ldr && vec_in_loader && !st.lock[LK_APP_HIGH]
    |=> irq_mask)
    else $error("interrupts not masked in application code");

endmodule

// ==== hw/fsg_pkg.sv ====
// Constants, types and register map of the flash section guard
//
// Contract
// - Region choice follows programmed address, not fetch
// - Concurrent-region program keeps CPU running
// - Stall-region program halts CPU whole operation
// - Loader section always inside stall region
// - Busy flag reads one while region blocked
// - Busy flag sticky until software clears it
// - Re-enable bit write clears busy flag when idle
// - Store operation starts only from loader code
// - Two independent lock pairs, application and loader
// - Locks programmed anytime, erased by chip erase
// - General lock modes never gate store/load
// - Application mode 1 allows everything
// - Application mode 2 blocks stores to application
// - Application mode 3 blocks stores, loader loads
// - Application mode 4 blocks loader loads; masks
// - Loader mode 1 allows everything
// - Loader mode 2 blocks stores to loader
// - Loader mode 3 blocks stores, application loads
// - Loader mode 4 blocks application loads; masks
package fsg_pkg;

  // Flash word address width and default section boundaries
  localparam int          ADDR_W        = 14;
  localparam logic [13:0] STALL_START_D = 14'h3800;
  localparam logic [13:0] LDR_START_D   = 14'h3C00;

  // Programming time, in nanoseconds, and clock rate
  localparam int PROG_TIME_NS  = 4000;
  localparam int CLK_MHZ       = 250;
  localparam int PROG_CYCLES_D = (PROG_TIME_NS * CLK_MHZ) / 1000;
  localparam int CNT_W         = 16;

  // APB register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_LOCK = 12'h004;

  // Control/status register fields
  localparam int CS_BUSY     = 0;
  localparam int CS_REENABLE = 1;
  localparam int CS_ACTIVE   = 2;
  localparam int CS_STALL    = 3;

  // Lock register fields; 1 = unprogrammed, 0 = programmed
  localparam int          LK_APP_LOW  = 0;
  localparam int          LK_APP_HIGH = 1;
  localparam int          LK_LDR_LOW  = 2;
  localparam int          LK_LDR_HIGH = 3;
  localparam logic [3:0]  LOCK_RESET  = 4'hF;

  // Store operation kinds on the op_kind port
  localparam logic [1:0] OPK_ERASE = 2'h0;
  localparam logic [1:0] OPK_WRITE = 2'h1;
  localparam logic [1:0] OPK_LOCK  = 2'h2;

  // Guard sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_PROG
  } fsg_state_type;

endpackage

// ==== test/fsg_cpu_model.sv ====
// CPU core model issuing fetches, store operations and loads
`timescale 1ns/1ps
module fsg_cpu_model
  import fsg_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              busy,
  output logic      [ADDR_W-1:0] fetch_addr,
  output logic                   op_req,
  output logic      [1:0]        op_kind,
  output logic      [ADDR_W-1:0] op_addr,
  output logic      [3:0]        op_data,
  output logic                   lpm_req,
  output logic      [ADDR_W-1:0] lpm_addr,
  output logic                   vec_in_loader
);
  // Idle values at time zero, executing loader code
  initial begin
    fetch_addr    = LDR_START_D;
    op_req        = 1'b0;
    op_kind       = OPK_ERASE;
    op_addr       = '0;
    op_data       = 4'hF;
    lpm_req       = 1'b0;
    lpm_addr      = '0;
    vec_in_loader = 1'b0;
  end
  // Move execution point and vector placement
  task automatic run_at(input logic [ADDR_W-1:0] a, input logic v);
    @(posedge pclk);
    fetch_addr    <= a;
    vec_in_loader <= v;
  endtask
  // One-cycle store request; address not held afterwards
  task automatic store(input logic [1:0] k,
                       input logic [ADDR_W-1:0] a);
    @(posedge pclk);
    op_req  <= 1'b1;
    op_kind <= k;
    op_addr <= a;
    if (a < STALL_START_D) vec_in_loader <= 1'b1;
    @(posedge pclk);
    op_req  <= 1'b0;
    op_addr <= ~a;
  endtask
  // One-cycle load; never aims at a busy concurrent region
  task automatic load(input logic [ADDR_W-1:0] a);
    @(posedge pclk);
    if (busy && a < STALL_START_D) return;
    lpm_req  <= 1'b1;
    lpm_addr <= a;
    @(posedge pclk);
    lpm_req  <= 1'b0;
    lpm_addr <= ~a;
  endtask
  // One-cycle lock-set request carrying new lock bits
  task automatic lock_set(input logic [3:0] d);
    @(posedge pclk);
    op_req  <= 1'b1;
    op_kind <= OPK_LOCK;
    op_data <= d;
    @(posedge pclk);
    op_req  <= 1'b0;
    op_data <= 4'hF;
  endtask
endmodule

// ==== test/fsg_guard_tb_top.sv ====
// Self-checking bench for the flash section guard
`timescale 1ns/1ps
module fsg_guard_tb_top
  import fsg_pkg::*;
;
  localparam int PC = 8;  // Shortened programming time
  logic              pclk, presetn, psel, penable, pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, chip_erase, ext_lock_wr;
  logic [3:0]        ext_lock_data, op_data, lk;
  logic [ADDR_W-1:0] fetch_addr, op_addr, lpm_addr, la, lb;
  logic [1:0]        op_kind;
  logic              op_req, lpm_req, vec_in_loader, cpu_halt;
  logic              region_blocked, op_active, op_accept, op_reject;
  logic              lpm_grant, lpm_deny, irq_mask;
  logic              q_op[$], q_lpm[$];  // Expected answers
  logic [32:0]       q_rd[$];            // Expected pslverr and data
  logic [1:0]        hl[4] = '{2'b11, 2'b10, 2'b00, 2'b01}; // Modes
  int                n_mismatch = 0, cmp_count = 0, seed = 3;

  fsg_guard #(.PROG_CYCLES(PC)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .op_req(op_req), .op_kind(op_kind),
    .op_addr(op_addr), .op_data(op_data), .lpm_req(lpm_req),
    .lpm_addr(lpm_addr), .vec_in_loader(vec_in_loader),
    .chip_erase(chip_erase), .ext_lock_wr(ext_lock_wr),
    .ext_lock_data(ext_lock_data), .cpu_halt(cpu_halt),
    .region_blocked(region_blocked), .op_active(op_active),
    .op_accept(op_accept), .op_reject(op_reject),
    .lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .irq_mask(irq_mask));
  fsg_cpu_model cpu (
    .pclk(pclk), .busy(region_blocked), .fetch_addr(fetch_addr),
    .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr),
    .op_data(op_data), .lpm_req(lpm_req), .lpm_addr(lpm_addr),
    .vec_in_loader(vec_in_loader));

  // Clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Bit and word comparisons
  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; reads leave a note
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int i;
    if (!w) q_rd.push_back(e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!pready && i < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!pready) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  // Store and load requests with their expected answers
  task automatic op(input logic [1:0] k, input logic [ADDR_W-1:0] a,
                    input logic e);
    q_op.push_back(e);
    cpu.store(k, a);
    @(negedge pclk);
  endtask
  task automatic ld(input logic [ADDR_W-1:0] a, input logic e);
    q_lpm.push_back(e);
    cpu.load(a);
    @(negedge pclk);
  endtask
  // Wait for the operation to end; count halted cycles
  task automatic run_out(input logic [32:0] e);
    logic [32:0] n;
    int          i;
    n = '0;
    for (i = 0; i < 40 && op_active; i++) begin
      @(posedge pclk);
      n = n + 33'(cpu_halt);
    end
    if (i == 40) begin
      n_mismatch++;
      print_verdict();
    end
    chk_word(n, e);
    @(negedge pclk);
  endtask
  // Match each answer with the oldest note
  always @(posedge pclk) begin
    if (op_accept || op_reject) begin
      if (q_op.size() > 0) chk_bit(op_accept, q_op.pop_front());
      else chk_bit(1'b1, 1'b0);
    end
    if (lpm_grant || lpm_deny) begin
      if (q_lpm.size() > 0) chk_bit(lpm_grant, q_lpm.pop_front());
      else chk_bit(1'b1, 1'b0);
    end
    if (psel && penable && pready && !pwrite && q_rd.size() > 0)
      chk_word({pslverr, prdata}, q_rd.pop_front());
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, chip_erase, ext_lock_wr} = '0;
    paddr = '0;
    pwdata = '0;
    ext_lock_data = 4'hF;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_LOCK, 0, {5'h0, 24'h0, LOCK_RESET});
    apb(0, OFS_CTRL, 0, 33'h0);
    apb(0, 12'h008, 0, {1'b1, 32'h0});
    $display("register reset test done");
    cpu.run_at(14'h0100, 1'b0);
    op(OPK_WRITE, 14'h0200, 1'b0);
    cpu.run_at(LDR_START_D, 1'b0);
    op(2'h3, 14'h3900, 1'b0);
    op(OPK_WRITE, 14'h0200, 1'b1);
    chk_bit(region_blocked, 1'b1);
    chk_bit(op_active, 1'b1);
    ld(14'h3A00, 1'b1);
    op(OPK_ERASE, 14'h3900, 1'b0);
    run_out(33'h0);
    apb(0, OFS_CTRL, 0, 33'h1);
    apb(1, OFS_CTRL, 32'h2, 0);
    apb(0, OFS_CTRL, 0, 33'h0);
    $display("concurrent region test done");
    op(OPK_ERASE, 14'h3900, 1'b1);
    run_out(33'(PC));
    apb(0, OFS_CTRL, 0, 33'h8);
    $display("stall region test done");
    for (int m = 0; m < 4; m++) begin
      lk = {hl[3-m], hl[m]};
      la = {4'hE, 10'($random(seed))};
      lb = {4'hF, 10'($random(seed))};
      @(posedge pclk);
      chip_erase <= 1'b1;
      @(posedge pclk);
      chip_erase <= 1'b0;
      if (m[0]) begin
        ext_lock_wr   <= 1'b1;
        ext_lock_data <= lk;
        @(posedge pclk);
        ext_lock_wr   <= 1'b0;
      end else begin
        apb(1, OFS_LOCK, {28'h0, lk}, 0);
      end
      apb(0, OFS_LOCK, 0, {29'h0, lk});
      cpu.run_at(LDR_START_D, 1'b0);
      op(OPK_WRITE, la, lk[0]);
      run_out(lk[0] ? 33'(PC) : 33'h0);
      op(OPK_ERASE, lb, lk[2]);
      run_out(lk[2] ? 33'(PC) : 33'h0);
      ld(la, lk[1]);
      cpu.run_at(14'h0100, 1'b1);
      ld(lb, lk[3]);
      chk_bit(irq_mask, !lk[1]);
      cpu.run_at(LDR_START_D, 1'b0);
      repeat (2) @(negedge pclk);
      chk_bit(irq_mask, !lk[3]);
      $display("lock mode test %0d done", m + 1);
    end
    // Lock-set store from loader code, then a store it blocks
    @(posedge pclk);
    chip_erase <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b0;
    q_op.push_back(1'b1);
    cpu.lock_set(4'hE);
    @(negedge pclk);
    apb(0, OFS_LOCK, 0, {29'h0, 4'hE});
    op(OPK_WRITE, 14'h3900, 1'b0);
    $display("lock set test done");
    repeat (4) @(posedge pclk);
    // Every note must have met its answer
    if (q_op.size() + q_lpm.size() + q_rd.size() != 0) n_mismatch++;
    print_verdict();
  end
endmodule
